// >>> pmcs_consts.svh
// Constants of the power mode clock selector: field positions, codes,
// reset values and timing counts.
// Assumes inclusion by bare name from the switcher and top modules.
`ifndef PMCS_CONSTS_SVH
`define PMCS_CONSTS_SVH

// Register offsets (byte addresses on APB).
`define PMCS_OFF_OSC_CTRL 12'h000
`define PMCS_OFF_STATUS 12'h004
`define PMCS_OFF_SLEEP_CMD 12'h008
`define PMCS_OFF_WAKE 12'h00C
`define PMCS_OFF_STACK 12'h010
`define PMCS_OFF_PC 12'h014
`define PMCS_OFF_FIRST_IO_PORT 12'h018

// Oscillator control field positions.
`define PMCS_IDLE_BIT 7
`define PMCS_SRC_HI 1
`define PMCS_SRC_LO 0

// Clock source field codes.
`define PMCS_SRC_PRIMARY 2'h2
`define PMCS_SRC_SECONDARY 2'h1
`define PMCS_SRC_INTERNAL 2'h3

// Reset values.
`define PMCS_OSC_CTRL_RESET 8'h02
`define PMCS_PC_RESET 21'h000000
`define PMCS_SP_RESET 5'h00

// Interrupt vectors.
`define PMCS_VEC_HIGH 21'h000008
`define PMCS_VEC_LOW 21'h000018

// Clock switch settle time in ns and the derived cycle count.
`define PMCS_SWITCH_NS 100
`define PMCS_CLK_NS 20
`define PMCS_SWITCH_CYC ((`PMCS_SWITCH_NS + `PMCS_CLK_NS - 1) / `PMCS_CLK_NS)

`endif

// >>> pmcs_pkg.sv
// Types shared by the power mode clock selector modules.
// Assumes pmcs_consts.svh supplies the numeric constants.
package pmcs_pkg;

    // Operating modes of the device.
    typedef enum logic [2:0] {
        PMCS_PRIMARY_RUN_MODE,
        PMCS_SECONDARY_RUN_MODE,
        PMCS_INT_RUN,
        PMCS_PRIMARY_IDLE_MODE,
        PMCS_SECONDARY_IDLE_MODE,
        PMCS_INT_IDLE,
        PMCS_SLEEP
    } pmcs_mode_type;

    // States of the clock switcher.
    typedef enum logic [1:0] {
        PMCS_SW_STEADY,
        PMCS_SW_WAIT,
        PMCS_SW_SETTLE
    } pmcs_sw_state_type;

endpackage : pmcs_pkg

// >>> pmcs_sw_if.sv
// Interface between the mode controller and the clock switcher.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ns
interface pmcs_sw_if;
    logic [1:0] want_src;
    logic [2:0] src_running;
    logic [1:0] cur_src;
    logic busy;

    modport ctrl (output want_src, output src_running,
                  input cur_src, input busy);
    modport sw (input want_src, input src_running,
                output cur_src, output busy);
endinterface : pmcs_sw_if

// >>> pmcs_switch.sv
// Clock source switcher: holds the current source until the new one runs,
// then changes over after a settle interval.
// Assumes source running flags are already synchronised to clk.
`timescale 1ns/1ns
`include "pmcs_consts.svh"
module pmcs_switch #(
    parameter int SETTLE_CYC = `PMCS_SWITCH_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Link to the mode controller.
    pmcs_sw_if.sw sw
);

    typedef struct packed {
        pmcs_pkg::pmcs_sw_state_type state;
        logic [1:0] cur;
        logic [7:0] cnt;
    } pmcs_sw_regs_type;

    pmcs_sw_regs_type r;
    pmcs_sw_regs_type next_r;

    // Running flag of the source with a given code.
    function automatic logic src_ok(input logic [1:0] s,
                                    input logic [2:0] run);
        src_ok = 1'b0;
        unique case (s)
            `PMCS_SRC_PRIMARY: src_ok = run[0];
            `PMCS_SRC_SECONDARY: src_ok = run[1];
            `PMCS_SRC_INTERNAL: src_ok = run[2];
            default: src_ok = 1'b0;
        endcase
    endfunction : src_ok

    // Next state: the old source keeps clocking while the new one is
    // not running, so no runt pulse can reach the device clock.
    always_comb begin
        next_r = r;
        unique case (r.state)
            pmcs_pkg::PMCS_SW_STEADY: begin
                if (sw.want_src != r.cur && sw.want_src != 2'h0) begin
                    next_r.state = pmcs_pkg::PMCS_SW_WAIT;
                end
            end
            pmcs_pkg::PMCS_SW_WAIT: begin
                if (sw.want_src == r.cur) begin
                    next_r.state = pmcs_pkg::PMCS_SW_STEADY;
                end else if (src_ok(sw.want_src, sw.src_running)) begin
                    next_r.state = pmcs_pkg::PMCS_SW_SETTLE;
                    next_r.cnt = SETTLE_CYC[7:0];
                end
            end
            pmcs_pkg::PMCS_SW_SETTLE: begin
                if (r.cnt <= 8'h01) begin
                    next_r.cur = sw.want_src;
                    next_r.state = pmcs_pkg::PMCS_SW_STEADY;
                    next_r.cnt = 8'h00;
                end else begin
                    next_r.cnt = r.cnt - 8'h01;
                end
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '{pmcs_pkg::PMCS_SW_STEADY, `PMCS_SRC_PRIMARY, 8'h00};
        end else begin
            r <= next_r;
        end
    end

    assign sw.cur_src = r.cur;
    assign sw.busy = (r.state != pmcs_pkg::PMCS_SW_STEADY);

endmodule : pmcs_switch

// >>> pmcs_top.sv
// Power mode controller: Run, Idle and Sleep modes, clock source choice,
// wake-up handling of stack and program counter, and port A pin gating.
// Assumes APB master on clk, and oscillator, sleep and wake inputs that
// come from other logic or pins; pin inputs are synchronised here.
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "pmcs_consts.svh"
module pmcs_top #(
    parameter int SETTLE_CYC = `PMCS_SWITCH_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Oscillator running flags from the sources (asynchronous).
    input wire logic pri_running,
    input wire logic sec_running,
    input wire logic int_running,
    // CPU events on clk.
    input wire logic sleep_exec,
    input wire logic [20:0] cpu_pc,
    // Wake-up requests (asynchronous).
    input wire logic wake_irq,
    input wire logic wake_irq_high,
    input wire logic wake_wdt,
    // Strap: primary oscillator mode uses the two port A pins.
    input wire logic osc_uses_pins,
    // Port A pins 6 and 7 raw input.
    input wire logic [1:0] first_io_port_hi_in,
    // Clock gating and source enables.
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic pri_osc_en,
    output logic sec_osc_en,
    output logic int_osc_en,
    output logic [1:0] clk_src_sel,
    output logic [2:0] mode,
    // Wake-up results for the core.
    output logic pc_load,
    output logic [20:0] pc_value,
    output logic [20:0] stack_top,
    output logic [4:0] stack_index_reg,
    output logic [7:0] wake_flags,
    // Port A pins 6 and 7 as seen by software.
    output logic [1:0] first_io_port_hi_val
);

    ////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic [7:0] oscillator_control_reg;
        pmcs_pkg::pmcs_mode_type mode;
        logic [2:0] run_s1;
        logic [2:0] run_s2;
        logic [2:0] wake_s1;
        logic [2:0] wake_s2;
        logic [1:0] pa_s1;
        logic [1:0] pa_s2;
        logic pins_strap;
        logic strap_done;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic cpu_en;
        logic per_en;
        logic pri_en;
        logic sec_en;
        logic int_en;
        logic [1:0] src;
        logic pc_load;
        logic [20:0] pc_value;
        logic [20:0] stack_top;
        logic [4:0] sp;
        logic [7:0] wake_flags;
        logic [1:0] first_io_port;
    } pmcs_top_regs_type;

    pmcs_top_regs_type r;
    pmcs_top_regs_type next_r;
    pmcs_sw_if swl();

    logic idle_select_bit;
    logic [1:0] clock_source_field;
    logic access;
    logic wr;
    logic sleeping;
    logic any_wake;
    logic gie_ok;
    logic [31:0] rd;

    assign idle_select_bit = r.oscillator_control_reg[`PMCS_IDLE_BIT];
    assign clock_source_field =
        r.oscillator_control_reg[`PMCS_SRC_HI:`PMCS_SRC_LO];
    assign access = psel && penable && r.pready;
    assign wr = access && pwrite;
    assign sleeping = (r.mode == pmcs_pkg::PMCS_SLEEP);
    assign any_wake = |r.wake_s2;
    // Bit 7 and bit 6 of the wake register act as the two global enables.
    assign gie_ok = r.wake_flags[7] | r.wake_flags[6];

    ////////////////////////////////////////////////////////////////////////
    // Clock switcher.

    assign swl.want_src = clock_source_field;
    assign swl.src_running = r.run_s2;

    pmcs_switch #(
        .SETTLE_CYC(SETTLE_CYC)
    ) u_switch (
        .clk(clk),
        .arst_n(arst_n),
        .sw(swl)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero with an error.

    always_comb begin
        rd = 32'h00000000;
        unique case (paddr)
            `PMCS_OFF_OSC_CTRL: rd = {24'h000000, r.oscillator_control_reg};
            `PMCS_OFF_STATUS: rd = {24'h000000, swl.busy, r.mode,
                                   swl.cur_src, 2'h0};
            `PMCS_OFF_SLEEP_CMD: rd = 32'h00000000;
            `PMCS_OFF_WAKE: rd = {24'h000000, r.wake_flags};
            `PMCS_OFF_STACK: rd = {6'h00, r.sp, r.stack_top};
            `PMCS_OFF_PC: rd = {11'h000, r.pc_value};
            `PMCS_OFF_FIRST_IO_PORT: rd = {30'h00000000, r.first_io_port};
            default: rd = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        next_r = r;
        // Two-stage synchronisers on every asynchronous input.
        next_r.run_s1 = {int_running, sec_running, pri_running};
        next_r.run_s2 = r.run_s1;
        next_r.wake_s1 = {wake_wdt, wake_irq_high, wake_irq};
        next_r.wake_s2 = r.wake_s1;
        next_r.pa_s1 = first_io_port_hi_in;
        next_r.pa_s2 = r.pa_s1;
        // The strap is caught once after reset release.
        if (!r.strap_done) begin
            next_r.pins_strap = osc_uses_pins;
            next_r.strap_done = 1'b1;
        end
        next_r.pc_load = 1'b0;

        // APB: one wait state, answer at the second access cycle.
        next_r.pready = psel && penable && !r.pready;
        next_r.pslverr = 1'b0;
        if (psel && penable && !r.pready) begin
            next_r.prdata = pwrite ? 32'h00000000 : rd;
            next_r.pslverr = (paddr > `PMCS_OFF_FIRST_IO_PORT) || (paddr[1:0] != 2'h0);
        end
        if (wr && paddr == `PMCS_OFF_OSC_CTRL) begin
            next_r.oscillator_control_reg = {pwdata[7], 5'h00, pwdata[1:0]};
        end
        if (wr && paddr == `PMCS_OFF_WAKE) begin
            // Software writes the enables and clears cause flags by ones.
            next_r.wake_flags[7:6] = pwdata[7:6];
            next_r.wake_flags[2:0] = r.wake_flags[2:0] & ~pwdata[2:0];
        end

        // Mode tracking in Run; Idle or Sleep only by the sleep command.
        if (r.mode inside {pmcs_pkg::PMCS_PRIMARY_RUN_MODE, pmcs_pkg::PMCS_SECONDARY_RUN_MODE,
                           pmcs_pkg::PMCS_INT_RUN}) begin
            unique case (swl.cur_src)
                `PMCS_SRC_SECONDARY: next_r.mode = pmcs_pkg::PMCS_SECONDARY_RUN_MODE;
                `PMCS_SRC_INTERNAL: next_r.mode = pmcs_pkg::PMCS_INT_RUN;
                default: next_r.mode = pmcs_pkg::PMCS_PRIMARY_RUN_MODE;
            endcase
            if (sleep_exec || (wr && paddr == `PMCS_OFF_SLEEP_CMD)) begin
                if (!idle_select_bit) begin
                    next_r.mode = pmcs_pkg::PMCS_SLEEP;
                end else begin
                    unique case (swl.cur_src)
                        `PMCS_SRC_SECONDARY:
                            next_r.mode = pmcs_pkg::PMCS_SECONDARY_IDLE_MODE;
                        `PMCS_SRC_INTERNAL:
                            next_r.mode = pmcs_pkg::PMCS_INT_IDLE;
                        default: next_r.mode = pmcs_pkg::PMCS_PRIMARY_IDLE_MODE;
                    endcase
                end
            end
        end else if (any_wake) begin
            // Wake returns to the Run mode of the current source.
            unique case (swl.cur_src)
                `PMCS_SRC_SECONDARY: next_r.mode = pmcs_pkg::PMCS_SECONDARY_RUN_MODE;
                `PMCS_SRC_INTERNAL: next_r.mode = pmcs_pkg::PMCS_INT_RUN;
                default: next_r.mode = pmcs_pkg::PMCS_PRIMARY_RUN_MODE;
            endcase
            // Cause flags; the hardware set wins over a software clear.
            next_r.wake_flags[2:0] = next_r.wake_flags[2:0] | r.wake_s2;
            if ((r.wake_s2[0] || r.wake_s2[1]) && gie_ok) begin
                next_r.stack_top = cpu_pc;
                next_r.sp = r.sp + 5'h01;
                next_r.pc_value = r.wake_s2[1] ? `PMCS_VEC_HIGH
                                               : `PMCS_VEC_LOW;
                next_r.pc_load = 1'b1;
            end
        end

        // Clock enables and source enables per mode.
        unique case (next_r.mode)
            pmcs_pkg::PMCS_SLEEP: begin
                next_r.cpu_en = 1'b0;
                next_r.per_en = 1'b0;
            end
            pmcs_pkg::PMCS_PRIMARY_IDLE_MODE, pmcs_pkg::PMCS_SECONDARY_IDLE_MODE,
            pmcs_pkg::PMCS_INT_IDLE: begin
                next_r.cpu_en = 1'b0;
                next_r.per_en = 1'b1;
            end
            default: begin
                next_r.cpu_en = 1'b1;
                next_r.per_en = 1'b1;
            end
        endcase
        // Primary runs in primary run and primary idle, and in any Run mode while the source field asks for it.
        next_r.pri_en = (next_r.mode == pmcs_pkg::PMCS_PRIMARY_RUN_MODE) ||
                        (next_r.mode == pmcs_pkg::PMCS_PRIMARY_IDLE_MODE) ||
                        (clock_source_field == `PMCS_SRC_PRIMARY &&
                         next_r.cpu_en);
        next_r.sec_en = !(next_r.mode == pmcs_pkg::PMCS_SLEEP) &&
                        (clock_source_field == `PMCS_SRC_SECONDARY ||
                         swl.cur_src == `PMCS_SRC_SECONDARY);
        next_r.int_en = !(next_r.mode == pmcs_pkg::PMCS_SLEEP) &&
                        (clock_source_field == `PMCS_SRC_INTERNAL ||
                         swl.cur_src == `PMCS_SRC_INTERNAL);
        next_r.src = swl.cur_src;

        // Port A bits 6 and 7 read zero while the oscillator owns them.
        next_r.first_io_port = r.pins_strap ? 2'h0 : r.pa_s2;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
            r.oscillator_control_reg <= `PMCS_OSC_CTRL_RESET;
            r.mode <= pmcs_pkg::PMCS_PRIMARY_RUN_MODE;
            r.cpu_en <= 1'b1;
            r.per_en <= 1'b1;
            r.pri_en <= 1'b1;
            r.src <= `PMCS_SRC_PRIMARY;
            r.pc_value <= `PMCS_PC_RESET;
            r.sp <= `PMCS_SP_RESET;
            r.pins_strap <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flip-flops.
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign cpu_clk_en = r.cpu_en;
    assign periph_clk_en = r.per_en;
    assign pri_osc_en = r.pri_en;
    assign sec_osc_en = r.sec_en;
    assign int_osc_en = r.int_en;
    assign clk_src_sel = r.src;
    assign mode = r.mode;
    assign pc_load = r.pc_load;
    assign pc_value = r.pc_value;
    assign stack_top = r.stack_top;
    assign stack_index_reg = r.sp;
    assign wake_flags = r.wake_flags;
    assign first_io_port_hi_val = r.first_io_port;

endmodule : pmcs_top

// >>> pmcs_osc_model.sv
// Model of the three clock sources beside the selector.
// Assumes enables from the selector and hold-on controls from the bench.
`timescale 1ns/1ns
module pmcs_osc_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Enables: bit 0 primary, bit 1 secondary, bit 2 internal.
    input wire logic [2:0] osc_en,
    input wire logic [2:0] keep_on,
    input wire logic slow,
    // Running flags in the same bit order.
    output logic [2:0] running
);
    logic [2:0] sh [8];
    ////////////////////////////////////////////////////////////////////
    // A source starts one or eight cycles after it is wanted, and stops one cycle after it is not,
    // so a slow start shows whether the selector waits for it.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sh <= '{default: 3'h0};
        end else begin
            sh[0] <= osc_en | keep_on;
            for (int i = 1; i < 8; i++) begin
                sh[i] <= sh[i-1] & (osc_en | keep_on);
            end
        end
    end
    assign running = slow ? sh[7] : sh[0];
endmodule : pmcs_osc_model

// >>> pmcs_checker.sv
// Concurrent checks on the ports of the power mode selector.
// Assumes one clock domain; bound to the top module at the foot.
`timescale 1ns/1ns
module pmcs_checker #(
    parameter int SETTLE_CYC = 5
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Inputs watched.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pri_running,
    input wire logic sec_running,
    input wire logic int_running,
    input wire logic sleep_exec,
    input wire logic [20:0] cpu_pc,
    input wire logic osc_uses_pins,
    // Outputs watched.
    input wire logic pready,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic pri_osc_en,
    input wire logic sec_osc_en,
    input wire logic int_osc_en,
    input wire logic [1:0] clk_src_sel,
    input wire logic [2:0] mode,
    input wire logic pc_load,
    input wire logic [20:0] pc_value,
    input wire logic [20:0] stack_top,
    input wire logic [4:0] stack_index_reg,
    input wire logic [7:0] wake_flags,
    input wire logic [1:0] first_io_port_hi_val
);
    logic [1:0] cmd_hist;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////
    // Sleep commands of the last two edges; a bus command lands late.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_hist <= 2'h0;
        end else begin
            cmd_hist <= {cmd_hist[0], sleep_exec |
                (psel & penable & pwrite & (paddr == 12'h008))};
        end
    end
    sequence run_s;
        mode < 3'h3;
    endsequence
    sequence parked_s;
        mode >= 3'h3;
    endsequence
    ////////////////////////////////////////////////////////////////////
    // Mode entry and the clocks of each mode.
    AST_ENTRY_BY_SLEEP: assert property (run_s ##1 parked_s |->
        |cmd_hist) else $error("Low power mode entered uncommanded.");
    AST_IDLE_PICK: assert property (sleep_exec and run_s |=>
        mode == 3'h6 || mode == $past(mode) + 3'h3)
        else $error("Sleep command gave the wrong mode.");
    AST_SLEEP_OFF: assert property (mode == 3'h6 |-> !cpu_clk_en &&
        !periph_clk_en && !pri_osc_en && !sec_osc_en && !int_osc_en)
        else $error("A clock runs in Sleep.");
    AST_IDLE_CLK: assert property (parked_s and mode != 3'h6 |->
        !cpu_clk_en && periph_clk_en) else $error("Idle clocks wrong.");
    AST_RUN_CLK: assert property (run_s |->
        cpu_clk_en && periph_clk_en) else $error("Run clocks wrong.");
    AST_SEC_SRC: assert property (mode == 3'h1 || mode == 3'h4 |->
        sec_osc_en && clk_src_sel == 2'h1) else $error("Secondary off.");
    AST_INT_SRC: assert property (mode == 3'h2 || mode == 3'h5 |->
        int_osc_en && clk_src_sel == 2'h3) else $error("Internal off.");
    AST_PRIMARY_IDLE_MODE: assert property (mode inside {[3'h3:3'h5]} |->
        pri_osc_en == (mode == 3'h3)) else $error("Primary enable wrong.");
    AST_NO_CODE_ZERO: assert property (clk_src_sel != 2'h0)
        else $error("Source code zero selected.");
    AST_SWITCH_WAITS: assert property ($changed(clk_src_sel) |->
        (clk_src_sel == 2'h1 ? $past(sec_running, 3) :
        clk_src_sel == 2'h3 ? $past(int_running, 3) :
        $past(pri_running, 3))) else $error("Switched to a dead source.");
    ////////////////////////////////////////////////////////////////////
    // Wake-up results, pins and the bus answer.
    AST_STACK_PUSH: assert property (pc_load |->
        stack_top == $past(cpu_pc) &&
        stack_index_reg == $past(stack_index_reg) + 5'h1)
        else $error("Stack not pushed on wake.");
    AST_VECTOR: assert property (pc_load |-> wake_flags[7:6] != 2'h0 &&
        pc_value == (wake_flags[1] ? 21'h000008 : 21'h000018))
        else $error("Wrong wake vector.");
    AST_PIN_MASK: assert property (osc_uses_pins |->
        first_io_port_hi_val == 2'h0) else $error("Oscillator pins read live.");
    AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("Bus answer late.");
endmodule : pmcs_checker
bind pmcs_top pmcs_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.clk, .arst_n,
    .psel, .penable, .pwrite, .paddr, .pri_running, .sec_running,
    .int_running, .sleep_exec, .cpu_pc, .osc_uses_pins, .pready,
    .cpu_clk_en, .periph_clk_en, .pri_osc_en, .sec_osc_en, .int_osc_en,
    .clk_src_sel, .mode, .pc_load, .pc_value, .stack_top,
    .stack_index_reg, .wake_flags, .first_io_port_hi_val);

// >>> test_power_mode_clock_selector.sv
// Bench of the power mode selector: APB tasks and mode sequences.
// Assumes the source model and the bound checker beside the design.
`timescale 1ns/1ns
module test_power_mode_clock_selector;
    logic clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic sleep_exec, wake_irq, wake_irq_high, wake_wdt, osc_uses_pins;
    logic [20:0] cpu_pc, pc_value, stack_top;
    logic [1:0] first_io_port_hi_in, first_io_port_hi_val, clk_src_sel, s;
    logic cpu_clk_en, periph_clk_en, pri_osc_en, sec_osc_en, int_osc_en;
    logic [2:0] mode, run, keep_on, r;
    logic pc_load, slow, idl;
    logic [4:0] stack_index_reg;
    logic [7:0] wake_flags;
    int mismatches, n_tests;
    pmcs_top #(.SETTLE_CYC(1)) uut (.clk, .arst_n, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pri_running(run[0]), .sec_running(run[1]), .int_running(run[2]),
        .sleep_exec, .cpu_pc, .wake_irq, .wake_irq_high, .wake_wdt,
        .osc_uses_pins, .first_io_port_hi_in, .cpu_clk_en, .periph_clk_en,
        .pri_osc_en, .sec_osc_en, .int_osc_en, .clk_src_sel, .mode,
        .pc_load, .pc_value, .stack_top, .stack_index_reg, .wake_flags,
        .first_io_port_hi_val);
    pmcs_osc_model osc (.clk, .arst_n, .keep_on, .slow, .running(run),
        .osc_en({int_osc_en, sec_osc_en, pri_osc_en}));
    ////////////////////////////////////////////////////////////////////
    // Shared tasks: compare, bus transfer, waits and the verdict.
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Holds the request until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] rd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic settle(input int c);
        repeat (c) @(negedge clk);
    endtask : settle
    // Bounded wait: 0 for a source, 1 for a Run mode, 2 for a PC load.
    task automatic poll(input int k, input logic [1:0] src);
        int n;
        n = 0;
        while (n < 60 && !(k == 0 ? clk_src_sel === src :
            k == 1 ? (mode < 3'h3) === 1'b1 : pc_load === 1'b1)) begin
            @(negedge clk);
            n++;
        end
    endtask : poll
    task automatic sleep_cmd(input logic by_bus);
        if (by_bus) begin
            apb(1'b1, 12'h008, 32'h0, q);
        end else begin
            @(posedge clk);
            sleep_exec <= 1'b1;
            @(posedge clk);
            sleep_exec <= 1'b0;
        end
        settle(2);
    endtask : sleep_cmd
    task automatic finish_test;
        if (mismatches == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////
    // Clock and watchdog; the run needs a few thousand cycles at most.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {arst_n, psel, penable, pwrite, sleep_exec, slow} = 6'h0;
        {wake_irq, wake_irq_high, wake_wdt, osc_uses_pins} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cpu_pc = 21'h012345;
        first_io_port_hi_in = 2'h2;
        keep_on = 3'h7;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        settle(4);
        check("mode", mode, 3'h0);
        apb(1'b0, 12'h000, 32'h0, q);
        check("osc_ctrl", q, 32'h02);
        apb(1'b0, 12'h004, 32'h0, q);
        check("status", q, 32'h08);
        apb(1'b0, 12'h018, 32'h0, q);
        check("pins", q, 32'h2);
        apb(1'b0, 12'h020, 32'h0, q);
        check("unmapped_err", err, 1'b1);
        // Every source in Run, then Sleep or Idle, then a timer wake.
        for (int i = 0; i < 6; i++) begin
            s = (i % 3 == 0) ? 2'h2 : (i % 3 == 1) ? 2'h1 : 2'h3;
            r = (i % 3 == 0) ? 3'h0 : (i % 3 == 1) ? 3'h1 : 3'h2;
            idl = (i >= 3);
            apb(1'b1, 12'h000, {24'h0, idl, 5'h0, s}, q);
            poll(0, s);
            check("run_mode", mode, r);
            sleep_cmd(i == 5);
            check("pm_mode", mode, idl ? r + 3'h3 : 3'h6);
            check("periph", periph_clk_en, idl);
            check("pri_en", pri_osc_en, idl && s == 2'h2);
            @(posedge clk);
            wake_wdt <= 1'b1;
            poll(1, 2'h0);
            check("wdt_cause", wake_flags[2], 1'b1);
            @(posedge clk);
            wake_wdt <= 1'b0;
            apb(1'b1, 12'h00C, 32'h07, q);
        end
        // Interrupt wakes with the enables set: high wins, then low.
        apb(1'b1, 12'h00C, 32'hC7, q);
        for (int j = 0; j < 2; j++) begin
            sleep_cmd(1'b0);
            @(posedge clk);
            wake_irq <= 1'b1;
            wake_irq_high <= (j == 0);
            poll(2, 2'h0);
            check("vector", pc_value, j == 0 ? 21'h8 : 21'h18);
            check("stack_top", stack_top, cpu_pc);
            check("stack_idx", stack_index_reg, j + 1);
            @(posedge clk);
            {wake_irq, wake_irq_high} <= 2'h0;
            settle(4);
            apb(1'b1, 12'h00C, 32'hC7, q);
        end
        // Without the enables the stack is left alone.
        apb(1'b1, 12'h00C, 32'h07, q);
        sleep_cmd(1'b0);
        @(posedge clk);
        wake_irq <= 1'b1;
        poll(1, 2'h0);
        check("no_push", stack_index_reg, 5'h2);
        check("irq_cause", wake_flags[0], 1'b1);
        @(posedge clk);
        wake_irq <= 1'b0;
        // Slow secondary: the old source stays until the new one runs.
        @(posedge clk);
        keep_on <= 3'h5;
        slow <= 1'b1;
        apb(1'b1, 12'h000, 32'h01, q);
        settle(6);
        check("held_src", clk_src_sel, 2'h3);
        @(posedge clk);
        keep_on <= 3'h7;
        poll(0, 2'h1);
        check("new_src", clk_src_sel, 2'h1);
        check("sec_en", sec_osc_en, 1'b1);
        // Second reset with the oscillator owning the two pins.
        @(posedge clk);
        arst_n <= 1'b0;
        osc_uses_pins <= 1'b1;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        settle(5);
        check("pins_val", first_io_port_hi_val, 2'h0);
        apb(1'b0, 12'h018, 32'h0, q);
        check("pins_reg", q, 32'h0);
        finish_test();
    end
endmodule : test_power_mode_clock_selector
